// ---- rtl/fri_interlock.sv ----
// module: cpu rewrite interlock, command sequencer and abort logic for on-chip flash
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
// ==========================================
module fri_interlock
   import fri_pkg::*;
#(
   parameter int OP_LEN = OP_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // classic wishbone slave
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [4:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatW,
   output logic [31:0] wbDatR,
   output logic wbAck,
   // interrupt events and pins
   input wire logic nmiEvent,
   input wire logic wdtEvent,
   input wire logic nmiPinHigh,
   // flash array side and dma hold
   output fri_cmd_t opCmd,
   output logic opStart,
   output logic opAbort,
   output logic dmaHold
);
   // ==========================================
   // bus decode
   logic wrAcc, rdAcc, selLo, abortEv, ramMode, clrModes;
   // writes land on the ack edge, so the master sees ack and the update together
   assign wrAcc = wbCyc && wbStb && wbWe && wbAck;
   // read data is captured a cycle early so it stands while ack is high
   assign rdAcc = wbCyc && wbStb && !wbWe && !wbAck;
   assign selLo = wbSel[0];
   // reset handled synchronously; events abort in either mode
   assign abortEv = nmiEvent || wdtEvent;
   // watchdog only re-initialises modes in the ram-resident mode
   assign clrModes = nmiEvent || (wdtEvent && ramMode);

   // ==========================================
   // state
   logic [7:0] modeAReg, modeANext, modeBReg, modeBNext;
   logic [2:0] armReg, armNext; // last write to each protected bit was zero
   logic [ADDR_W-1:0] targetReg, targetNext, firstReg, firstNext;
   fri_seq_t seqReg, seqNext;
   fri_op_t kindReg, kindNext;
   fri_cmd_t cmdReg, cmdNext;
   logic [31:0] cntReg, cntNext;
   logic [1:0] statReg, statNext;
   logic startReg, startNext, abortReg, abortNext, ackReg;
   logic [31:0] rdReg, rdNext;
   assign ramMode = !modeBReg[MODE_SEL_BIT];

   // ==========================================
   // next-state logic
   always_comb begin
      logic [2:0] wv;
      logic [2:0] cur;
      logic evenOk;
      wv = 3'b000;
      cur = {modeBReg[MODE_SEL_BIT], modeAReg[PROT2_BIT], modeAReg[REWR_EN_BIT]};
      evenOk = !targetReg[0] && (targetReg == firstReg);
      modeANext = modeAReg;
      modeBNext = modeBReg;
      armNext = armReg;
      targetNext = targetReg;
      firstNext = firstReg;
      seqNext = seqReg;
      kindNext = kindReg;
      cmdNext = cmdReg;
      cntNext = cntReg;
      statNext = statReg;
      startNext = 1'b0;
      abortNext = 1'b0;
      // protected bits: a one only lands right after a zero, with nmi pin high
      if (wrAcc && selLo && (wbAdr == MODE_A_OFS || wbAdr == MODE_B_OFS)) begin
         wv = (wbAdr == MODE_A_OFS) ?
            {cur[2], wbDatW[PROT2_BIT], wbDatW[REWR_EN_BIT]} :
            {wbDatW[MODE_SEL_BIT], cur[1:0]};
         for (int i = 0; i < 3; i++) begin
            if ((wbAdr == MODE_B_OFS) == (i == 2)) begin
               if (!wv[i]) begin
                  cur[i] = 1'b0;
                  armNext[i] = 1'b1;
               end else begin
                  if (armReg[i] && nmiPinHigh) begin
                     cur[i] = 1'b1;
                  end
                  armNext[i] = 1'b0;
               end
            end
         end
         modeANext[REWR_EN_BIT] = cur[0];
         modeANext[PROT2_BIT] = cur[1];
         modeBNext[MODE_SEL_BIT] = cur[2];
      end
      if (wrAcc && wbAdr == TARGET_OFS) begin
         targetNext = wbDatW[ADDR_W-1:0];
      end
      // status flags: write one to clear
      if (wrAcc && selLo && wbAdr == STATUS_OFS) begin
         statNext = statReg & ~wbDatW[1:0];
      end
      // command sequencer
      case (seqReg)
         SEQ_IDLE: begin
            if (wrAcc && selLo && wbAdr == CMD_OFS && modeAReg[REWR_EN_BIT]) begin
               firstNext = targetReg;
               if (wbDatW[7:0] == CODE_PROGRAM) begin
                  seqNext = SEQ_WAIT_DATA;
               end else if (wbDatW[7:0] == CODE_ERASE) begin
                  seqNext = SEQ_WAIT_CONF;
                  kindNext = OP_ERASE;
               end else if (wbDatW[7:0] == CODE_LOCK) begin
                  seqNext = SEQ_WAIT_CONF;
                  kindNext = OP_LOCK;
               end
            end
         end
         SEQ_WAIT_DATA: begin
            if (wrAcc && wbAdr == CMD_OFS) begin
               if (evenOk) begin
                  cmdNext = '{kind: OP_PROGRAM, addr: targetReg, data: wbDatW[15:0]};
                  startNext = 1'b1;
                  seqNext = SEQ_BUSY;
               end else begin
                  statNext[ADDR_ERR_BIT] = 1'b1;
                  seqNext = SEQ_IDLE;
               end
            end
         end
         SEQ_WAIT_CONF: begin
            if (wrAcc && wbAdr == CMD_OFS) begin
               seqNext = SEQ_IDLE;
               if (evenOk && wbDatW[7:0] == CODE_CONFIRM) begin
                  cmdNext = '{kind: kindReg, addr: targetReg, data: wbDatW[15:0]};
                  startNext = 1'b1;
                  seqNext = SEQ_BUSY;
               end else if (!evenOk) begin
                  statNext[ADDR_ERR_BIT] = 1'b1;
               end
            end
         end
         SEQ_BUSY: begin
            if (cntReg == 32'(OP_LEN - 1)) begin
               seqNext = SEQ_IDLE;
            end
         end
         default: seqNext = SEQ_IDLE;
      endcase
      cntNext = (seqNext == SEQ_BUSY && seqReg == SEQ_BUSY) ? cntReg + 32'h0000_0001 :
         32'h0000_0000;
      // interrupt abort stops the sequencer and any start in the same cycle, but an idle sequencer still accepts a command write
      if (abortEv) begin
         if (seqReg != SEQ_IDLE) begin
            seqNext = SEQ_IDLE;
            statNext[ABORT_BIT] = 1'b1;
         end
         abortNext = (seqReg == SEQ_BUSY);
         startNext = 1'b0;
         cntNext = 32'h0000_0000;
      end
      if (clrModes) begin
         modeANext = MODE_A_RST;
         modeBNext = MODE_B_RST;
         armNext = 3'b000;
      end
      modeANext[BUSY_N_BIT] = (seqNext != SEQ_BUSY);
      // read mux, unmapped offsets read zero
      rdNext = 32'h0000_0000;
      case (wbAdr)
         MODE_A_OFS: rdNext = {24'h00_0000, modeAReg};
         MODE_B_OFS: rdNext = {24'h00_0000, modeBReg};
         TARGET_OFS: rdNext = {12'h000, targetReg};
         STATUS_OFS: rdNext = {28'h000_0000, seqReg, statReg};
         default: rdNext = 32'h0000_0000;
      endcase
   end

   // ==========================================
   // registers
   always_ff @(posedge clk) begin
      if (reset) begin
         modeAReg <= MODE_A_RST;
         modeBReg <= MODE_B_RST;
         armReg <= 3'b000;
         targetReg <= '0;
         firstReg <= '0;
         seqReg <= SEQ_IDLE;
         kindReg <= OP_PROGRAM;
         cmdReg <= '0;
         cntReg <= 32'h0000_0000;
         statReg <= 2'b00;
         startReg <= 1'b0;
         abortReg <= 1'b1; // hardware reset aborts the array
         ackReg <= 1'b0;
         rdReg <= 32'h0000_0000;
      end else begin
         modeAReg <= modeANext;
         modeBReg <= modeBNext;
         armReg <= armNext;
         targetReg <= targetNext;
         firstReg <= firstNext;
         seqReg <= seqNext;
         kindReg <= kindNext;
         cmdReg <= cmdNext;
         cntReg <= cntNext;
         statReg <= statNext;
         startReg <= startNext;
         abortReg <= abortNext;
         ackReg <= wbCyc && wbStb && !wbAck;
         rdReg <= rdAcc ? rdNext : rdReg;
      end
   end

   // ==========================================
   // outputs
   assign wbAck = ackReg;
   assign wbDatR = rdReg;
   assign opCmd = cmdReg;
   assign opStart = startReg;
   assign opAbort = abortReg;
   // stalls dma in the rom-resident mode while the array is busy
   assign dmaHold = modeBReg[MODE_SEL_BIT] && !modeAReg[BUSY_N_BIT];

   // ==========================================
   // checks
   sequence progCode;
      wrAcc && wbAdr == CMD_OFS && wbDatW[7:0] == CODE_PROGRAM && seqReg == SEQ_IDLE
         && modeAReg[REWR_EN_BIT] && !abortEv;
   endsequence
   sequence dataWrite;
      wrAcc && wbAdr == CMD_OFS && !targetReg[0] && targetReg == firstReg && !abortEv;
   endsequence
   chk_nmi_clears_modes: assert property (@(posedge clk) disable iff (reset)
      nmiEvent |=> modeAReg[PROT2_BIT:REWR_EN_BIT] == 2'b00 && !modeBReg[MODE_SEL_BIT])
      else $error("nmi did not reset mode registers");
   chk_wdt_ram_clears: assert property (@(posedge clk) disable iff (reset)
      wdtEvent && ramMode |=> !modeAReg[REWR_EN_BIT] && !modeAReg[PROT2_BIT])
      else $error("watchdog did not reset modes in ram mode");
   chk_abort_halts_op: assert property (@(posedge clk) disable iff (reset)
      abortEv && seqReg == SEQ_BUSY |=> opAbort && seqReg == SEQ_IDLE && modeAReg[0])
      else $error("interrupt did not halt operation");
   chk_lone_one_ignored: assert property (@(posedge clk) disable iff (reset)
      wrAcc && wbAdr == MODE_A_OFS && selLo && wbDatW[REWR_EN_BIT] && !armReg[0]
         && !modeAReg[REWR_EN_BIT] |=> !modeAReg[REWR_EN_BIT])
      else $error("single one write set protected bit");
   chk_zero_one_sets: assert property (@(posedge clk) disable iff (reset)
      wrAcc && wbAdr == MODE_A_OFS && selLo && wbDatW[REWR_EN_BIT] && armReg[0]
         && nmiPinHigh && !clrModes |=> modeAReg[REWR_EN_BIT])
      else $error("zero-then-one write did not set bit");
   chk_prog_code: assert property (@(posedge clk) disable iff (reset)
      progCode |=> seqReg == SEQ_WAIT_DATA)
      else $error("program code was not accepted");
   chk_prog_sequence: assert property (@(posedge clk) disable iff (reset)
      (seqReg == SEQ_WAIT_DATA) ##0 dataWrite |=> opStart && opCmd.kind == OP_PROGRAM)
      else $error("program sequence did not start operation");
   chk_busy_low_run: assert property (@(posedge clk) disable iff (reset)
      opStart |-> !modeAReg[BUSY_N_BIT] && seqReg == SEQ_BUSY)
      else $error("busy flag not low while operation runs");
   chk_lock_confirm: assert property (@(posedge clk) disable iff (reset)
      seqReg == SEQ_WAIT_CONF && kindReg == OP_LOCK && wrAcc && wbAdr == CMD_OFS
         && wbDatW[7:0] == CODE_CONFIRM && !targetReg[0] && targetReg == firstReg
         && !abortEv |=> opStart && opCmd.kind == OP_LOCK && opCmd.addr == firstReg)
      else $error("lock confirm did not start operation");
   chk_dma_hold_busy: assert property (@(posedge clk) disable iff (reset)
      modeBReg[MODE_SEL_BIT] && seqReg == SEQ_BUSY |-> dmaHold)
      else $error("dma not held during rom mode operation");
endmodule // fri_interlock

// ---- rtl/fri_pkg.sv ----
// package: constants, states and carriers for the flash rewrite interlock
package fri_pkg;
   // ==========================================
   // register map (byte offsets)
   localparam logic [4:0] MODE_A_OFS = 5'h00; // flash_mode_reg_a
   localparam logic [4:0] MODE_B_OFS = 5'h04; // flash_mode_reg_b
   localparam logic [4:0] TARGET_OFS = 5'h08; // target flash address
   localparam logic [4:0] CMD_OFS = 5'h0C; // command code / data port
   localparam logic [4:0] STATUS_OFS = 5'h10; // sequencer status
   // ==========================================
   // field positions
   localparam int BUSY_N_BIT = 0; // flash_busy_n_flag in mode A
   localparam int REWR_EN_BIT = 1; // cpu_rewrite_enable in mode A
   localparam int PROT2_BIT = 2; // second_protect_bit in mode A
   localparam int MODE_SEL_BIT = 1; // rewrite_mode_select in mode B
   localparam int ABORT_BIT = 0; // sticky aborted flag in status
   localparam int ADDR_ERR_BIT = 1; // sticky bad-address flag in status
   // ==========================================
   // reset values
   localparam logic [7:0] MODE_A_RST = 8'h01;
   localparam logic [7:0] MODE_B_RST = 8'h00;
   // ==========================================
   // command codes (low byte of the command port)
   localparam logic [7:0] CODE_PROGRAM = 8'h40;
   localparam logic [7:0] CODE_ERASE = 8'h20;
   localparam logic [7:0] CODE_LOCK = 8'h77;
   localparam logic [7:0] CODE_CONFIRM = 8'hD0;
   // ==========================================
   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int OP_TIME_NS = 50000; // default automatic operation time
   localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADDR_W = 20;
   // ==========================================
   // sequencer states and operation kinds
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_WAIT_DATA = 2'b01,
      SEQ_WAIT_CONF = 2'b10,
      SEQ_BUSY = 2'b11
   } fri_seq_t;
   typedef enum logic [1:0] {
      OP_PROGRAM = 2'b00,
      OP_ERASE = 2'b01,
      OP_LOCK = 2'b10
   } fri_op_t;
   // operation handed to the flash array
   typedef struct packed {
      fri_op_t kind;
      logic [ADDR_W-1:0] addr;
      logic [15:0] data;
   } fri_cmd_t;
endpackage

// ---- test/fri_flash_model.sv ----
// flash array stand-in: records started commands and aborts for the bench
`timescale 1ns/1ns
module fri_flash_model
   import fri_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // sequencer side
   input wire fri_cmd_t opCmd,
   input wire logic opStart,
   input wire logic opAbort,
   // observation for the bench
   output logic [7:0] startCnt,
   output logic [7:0] abortCnt,
   output fri_cmd_t lastCmd
);
   // ==========================================
   // bookkeeping
   logic [7:0] startCnt_reg, startCnt_next, abortCnt_reg, abortCnt_next;
   fri_cmd_t lastCmd_reg, lastCmd_next;
   // next values: latch each command when it starts, count aborts
   always_comb begin
      startCnt_next = startCnt_reg + {7'h0, opStart};
      abortCnt_next = abortCnt_reg + {7'h0, opAbort};
      lastCmd_next = opStart ? opCmd : lastCmd_reg;
   end
   // registers; reset clears history, since abort stands high during reset
   always_ff @(posedge clk) begin
      if (reset) begin
         startCnt_reg <= 8'h00;
         abortCnt_reg <= 8'h00;
         lastCmd_reg <= '0;
      end else begin
         startCnt_reg <= startCnt_next;
         abortCnt_reg <= abortCnt_next;
         lastCmd_reg <= lastCmd_next;
      end
   end
   assign startCnt = startCnt_reg;
   assign abortCnt = abortCnt_reg;
   assign lastCmd = lastCmd_reg;
endmodule // fri_flash_model

// ---- test/fri_interlock_tb.sv ----
// self-checking bench for the flash rewrite interlock
`timescale 1ns/1ns
module fri_interlock_tb
   import fri_pkg::*;
;
   // ==========================================
   // signals
   logic clk, reset, wbCyc, wbStb, wbWe, wbAck, nmiEvent, wdtEvent, nmiPinHigh;
   logic opStart, opAbort, dmaHold;
   logic [4:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatW, wbDatR, rd;
   logic [7:0] startCnt, abortCnt;
   fri_cmd_t opCmd, lastCmd;
   int mismatches = 0;
   int numChecks = 0;
   // short operation time keeps the run brief
   fri_interlock #(.OP_LEN(8)) i_dut (.clk(clk), .reset(reset), .wbCyc(wbCyc),
      .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
      .wbDatR(wbDatR), .wbAck(wbAck), .nmiEvent(nmiEvent), .wdtEvent(wdtEvent),
      .nmiPinHigh(nmiPinHigh), .opCmd(opCmd), .opStart(opStart), .opAbort(opAbort),
      .dmaHold(dmaHold));
   fri_flash_model i_flash (.clk(clk), .reset(reset), .opCmd(opCmd), .opStart(opStart),
      .opAbort(opAbort), .startCnt(startCnt), .abortCnt(abortCnt), .lastCmd(lastCmd));
   // ==========================================
   // shared tasks
   task automatic summarize();
      $display("checks %0d mismatches %0d", numChecks, mismatches);
      if (mismatches == 0 && numChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      numChecks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // packs kind and address of a command for one compare
   function automatic logic [31:0] cmdWord(input fri_cmd_t c);
      return {10'h000, c.kind, c.addr};
   endfunction
   // classic cycle: hold everything until ack is sampled, then release
   task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat);
      int n;
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatW <= dat;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      rd = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (wbAck !== 1'b1) begin
         chk("wbAck", 32'h0000_0001, 32'h0000_0000);
         summarize();
      end
   endtask
   // zero then one, as protected bits need
   task automatic arm(input logic [4:0] adr, input logic [31:0] val);
      wb(1'b1, adr, 32'h0000_0000);
      wb(1'b1, adr, val);
   endtask
   task automatic pulse(input logic isNmi);
      @(posedge clk);
      nmiEvent <= isNmi;
      wdtEvent <= !isNmi;
      @(posedge clk);
      nmiEvent <= 1'b0;
      wdtEvent <= 1'b0;
   endtask
   // bounded wait for the flash model to see a start or an abort
   task automatic waitCnt(input logic isAbort, input logic [7:0] base);
      int n;
      for (n = 0; n < 40 && (isAbort ? abortCnt : startCnt) === base; n++) @(posedge clk);
      if (n == 40) begin
         chk("counter moved", 32'h0000_0001, 32'h0000_0000);
         summarize();
      end
   endtask
   task automatic issue(input logic [31:0] tgt, input logic [31:0] c1, input logic [31:0] c2);
      logic [7:0] base;
      base = startCnt;
      wb(1'b1, TARGET_OFS, tgt); // callers pass even targets only
      wb(1'b1, CMD_OFS, c1);
      wb(1'b1, CMD_OFS, c2);
      waitCnt(1'b0, base);
   endtask
   // ==========================================
   // scenarios
   task automatic tReset();
      wb(1'b0, MODE_A_OFS, 32'h0);
      chk("resetAbort", 32'h0000_0001, {24'h00_0000, abortCnt});
      chk("modeA", {24'h00_0000, MODE_A_RST}, rd);
      wb(1'b0, MODE_B_OFS, 32'h0);
      chk("modeB", {24'h00_0000, MODE_B_RST}, rd);
      wb(1'b0, 5'h14, 32'h0);
      chk("unmapped", 32'h0000_0000, rd);
   endtask
   task automatic tProtect();
      wb(1'b1, MODE_A_OFS, 32'h0000_0006);
      wb(1'b0, MODE_A_OFS, 32'h0);
      chk("loneOne", 32'h0000_0001, rd);
      wb(1'b1, MODE_A_OFS, 32'h0000_0000);
      nmiPinHigh <= 1'b0;
      wb(1'b1, MODE_A_OFS, 32'h0000_0006);
      nmiPinHigh <= 1'b1;
      wb(1'b0, MODE_A_OFS, 32'h0);
      chk("pinLow", 32'h0000_0001, rd);
      arm(MODE_A_OFS, 32'h0000_0006);
      wb(1'b0, MODE_A_OFS, 32'h0);
      chk("pairSet", 32'h0000_0007, rd);
   endtask
   task automatic tProgram();
      issue(32'h0000_0100, {24'h00_0000, CODE_PROGRAM}, 32'h0000_1234);
      chk("progCmd", {10'h000, OP_PROGRAM, 20'h0_0100}, cmdWord(lastCmd));
      chk("progData", 32'h0000_1234, {16'h0000, lastCmd.data});
      wb(1'b0, MODE_A_OFS, 32'h0);
      chk("busyLow", 32'h0000_0006, rd);
      chk("ramNoHold", 32'h0000_0000, {31'h0, dmaHold});
      repeat (10) @(posedge clk); // wait longer than the operation time
      wb(1'b0, MODE_A_OFS, 32'h0);
      chk("busyDone", 32'h0000_0007, rd);
   endtask
   // nmi in rom-resident mode during an erase
   task automatic tNmiRom();
      logic [7:0] base;
      arm(MODE_B_OFS, 32'h0000_0002);
      issue(32'h0000_0200, {24'h00_0000, CODE_ERASE}, {24'h00_0000, CODE_CONFIRM});
      chk("eraseCmd", {10'h000, OP_ERASE, 20'h0_0200}, cmdWord(lastCmd));
      chk("romHold", 32'h0000_0001, {31'h0, dmaHold});
      // reset already left one abort in the model, so count from here
      base = abortCnt;
      pulse(1'b1); // nmi only, no watchdog pulse; a watchdog would abort in rom mode too
      waitCnt(1'b1, base);
      chk("abortOnce", {24'h00_0000, base + 8'h01}, {24'h00_0000, abortCnt});
      wb(1'b0, MODE_A_OFS, 32'h0);
      chk("nmiModeA", 32'h0000_0001, rd);
      wb(1'b0, MODE_B_OFS, 32'h0);
      chk("nmiModeB", 32'h0000_0000, rd);
      wb(1'b0, STATUS_OFS, 32'h0);
      chk("abortFlag", 32'h0000_0001, {31'h0, rd[ABORT_BIT]});
   endtask
   // watchdog in ram-resident mode during a lock bit program
   task automatic tWdtRam();
      logic [7:0] base;
      arm(MODE_A_OFS, 32'h0000_0002);
      issue(32'h0000_07FE, {24'h00_0000, CODE_LOCK}, {24'h00_0000, CODE_CONFIRM});
      chk("lockCmd", {10'h000, OP_LOCK, 20'h0_07FE}, cmdWord(lastCmd));
      base = abortCnt;
      pulse(1'b0); // watchdog only, no nmi pulse
      waitCnt(1'b1, base);
      wb(1'b0, MODE_A_OFS, 32'h0);
      chk("wdtModeA", 32'h0000_0001, rd);
   endtask
   // ==========================================
   // clock and main sequence
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      {reset, wbCyc, wbStb, wbWe, nmiEvent, wdtEvent} = 6'h3F & 6'h20;
      nmiPinHigh = 1'b1;
      wbAdr = 5'h00;
      wbSel = 4'hF;
      wbDatW = 32'h0000_0000;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      tReset();
      tProtect();
      tProgram();
      tNmiRom();
      tWdtRam();
      summarize();
   end
endmodule // fri_interlock_tb
